// File: adc_serial_instruction_decoder_cfg.svh
// offsets, field positions, reset values and timing counts of the instruction decoder
`ifndef ADC_SERIAL_INSTRUCTION_DECODER_CFG_SVH
`define ADC_SERIAL_INSTRUCTION_DECODER_CFG_SVH

// instruction and word lengths in shift-clock bits
`define INSTR_BITS 5'h08
`define WORD_BASE_LEN 5'h0C
`define WORD_WIDE_EXTRA 5'h04
`define BIT_CNT_MAX 5'h1F

// acquisition lengths in conversion-clock cycles
`define ACQ_CLKS_6 6'h06
`define ACQ_CLKS_10 6'h0A
`define ACQ_CLKS_18 6'h12
`define ACQ_CLKS_34 6'h22

// status word bit positions
`define ST_PUP 0
`define ST_PDN 1
`define ST_CAL 2
`define ST_UNUSED 3
`define ST_FMT_NARROW 4
`define ST_FMT_WIDE 5
`define ST_SIGN 6
`define ST_MSB_FIRST 7
`define ST_TEST 8
`define STATUS_BITS 9

// power-on values
`define ACQ_IDX_RESET 2'h1
`define SIGN_RESET 1'h1
`define WIDE_RESET 1'h0
`define LSB_FIRST_RESET 1'h0
`define TEST_RESET 1'h0
`define LFSR_RESET 17'h00001

// sequence lengths in conversion-clock cycles
`define CONV_CLKS_DEF 16'h002C
`define CAL_CLKS_DEF 16'h0100
`define ZERO_CLKS_DEF 16'h004C
`define PUP_CLKS_DEF 16'h0020
`define PDN_CLKS_DEF 16'h0004

`endif

// File: adc_serial_instruction_decoder_pkg.sv
// types shared by the instruction decoder and its output word formatter
package adc_serial_instruction_decoder_pkg;

  typedef struct packed {
    logic wide;
    logic lsb_first;
    logic sign;
  } fmt_type;

  typedef struct packed {
    logic single_ended;
    logic polarity_odd;
    logic [1:0] pair;
  } chan_sel_type;

  typedef struct packed {
    logic conversion_clock;
    logic sclk;
    logic di;
    logic cs_n;
    logic conv_n;
    logic pd;
  } pin_sync_type;

  typedef enum logic [2:0] {SEQ_IDLE, SEQ_ACQ, SEQ_CONV, SEQ_CAL, SEQ_ZERO} seq_state_type;

  typedef enum logic [1:0] {OUT_RESULT, OUT_STATUS, OUT_GARBAGE} out_kind_type;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_CONV, CMD_CAL, CMD_ZERO, CMD_PUP, CMD_PDN,
    CMD_STATUS, CMD_SIGN, CMD_ACQ, CMD_USER, CMD_TEST
  } cmd_type;

  typedef struct packed {
    pin_sync_type s1;
    pin_sync_type s2;
    pin_sync_type s3;
    seq_state_type seq;
    logic [15:0] cnt;
    logic [15:0] pwr_cnt;
    logic powered;
    logic pup_busy;
    logic pdn_busy;
    logic sw_pd;
    fmt_type fmt;
    logic [1:0] acq_idx;
    logic test;
    chan_sel_type chan;
    logic [7:0] instr;
    logic [4:0] bit_cnt;
    logic [4:0] frame_len;
    logic reload;
    logic [16:0] out_sr;
    out_kind_type kind;
    logic [16:0] result;
    logic [16:0] lfsr;
    logic eoc;
  } core_state_type;

endpackage : adc_serial_instruction_decoder_pkg

// File: adc_word_formatter.sv
// lays a sign and magnitude out as an output word in shift order, bit 0 leaves first
`include "adc_serial_instruction_decoder_cfg.svh"
module adc_word_formatter (
  input wire adc_serial_instruction_decoder_pkg::fmt_type i_fmt,
  input wire logic i_sign,
  input wire logic [11:0] i_mag,
  output logic [16:0] o_word
);
  import adc_serial_instruction_decoder_pkg::*;

  logic [16:0] aligned;
  logic [4:0] len;

  // right-aligned core, zeros above it serve as padding and don't-care bits
  assign aligned = i_fmt.sign ? {4'h0, i_sign, i_mag} : {5'h00, i_mag};
  assign len = 5'(`WORD_BASE_LEN + (i_fmt.wide ? `WORD_WIDE_EXTRA : 5'h00)
               + {4'h0, i_fmt.sign});

  genvar gi;
  generate
    for (gi = 0; gi < 17; gi++) begin : g_pos
      logic [4:0] msb_idx;
      assign msb_idx = 5'(len - 5'h01 - 5'(gi));
      // msb-first reads the word from the top, lsb-first from the bottom
      assign o_word[gi] = i_fmt.lsb_first ? aligned[gi] :
                          ((5'(gi) < len) ? aligned[msb_idx] : 1'b0);
    end
  endgenerate

endmodule : adc_word_formatter

// File: adc_serial_instruction_decoder.sv
// serial instruction decoder, conversion sequencer and status word of the converter
`include "adc_serial_instruction_decoder_cfg.svh"
module adc_serial_instruction_decoder #(
  parameter logic [15:0] CONV_CLKS = `CONV_CLKS_DEF,
  parameter logic [15:0] CAL_CLKS = `CAL_CLKS_DEF,
  parameter logic [15:0] ZERO_CLKS = `ZERO_CLKS_DEF,
  parameter logic [15:0] PUP_CLKS = `PUP_CLKS_DEF,
  parameter logic [15:0] PDN_CLKS = `PDN_CLKS_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_serial_instr_in,
  input wire logic i_cs_n,
  input wire logic i_conv_n,
  input wire logic i_powerdown_pin,
  input wire logic i_conversion_clock,
  input wire logic i_sar_sign,
  input wire logic [11:0] i_sar_mag,
  output logic o_data_out,
  output logic o_eoc,
  output logic o_acquiring,
  output logic o_powered,
  output logic o_analog_channels_oe,
  output adc_serial_instruction_decoder_pkg::chan_sel_type o_chan
);
  import adc_serial_instruction_decoder_pkg::*;

  core_state_type st;
  core_state_type next_st;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic conversion_clock_rise;
  logic last_bit;
  logic frame_end;
  logic instr_ok;
  logic converting;
  logic powered_now;
  cmd_type dec_cmd;
  logic [`STATUS_BITS-1:0] status_word;
  logic [16:0] load_word;
  logic [16:0] fmt_word;
  logic [5:0] acq_len;
  logic [4:0] cur_len;

  function automatic cmd_type decode_instr(input logic [7:0] d);
    logic low_zero;
    low_zero = (d[3:0] == 4'h0);
    decode_instr = CMD_NONE;
    if (!d[4] && !d[6]) begin
      decode_instr = CMD_CONV;
    end else if (d[4] && !d[5] && low_zero) begin
      case ({d[6], d[7]})
        2'h0: decode_instr = CMD_CAL;
        2'h1: decode_instr = CMD_ZERO;
        2'h2: decode_instr = CMD_PUP;
        default: decode_instr = CMD_PDN;
      endcase
    end else if (d[4] && d[5] && !d[6]) begin
      if (!d[7] && low_zero) begin
        decode_instr = CMD_STATUS;
      end else if (d[7] && d[3:1] == 3'h0) begin
        decode_instr = CMD_SIGN;
      end
    end else if (d[4] && d[5] && d[6] && !d[7] && d[3:2] == 2'h0) begin
      decode_instr = CMD_ACQ;
    end else if (d[4] && d[5] && d[6] && d[7]) begin
      if (d[0]) begin
        decode_instr = CMD_TEST;
      end else if (low_zero) begin
        decode_instr = CMD_USER;
      end
    end
  endfunction : decode_instr

  function automatic logic [5:0] acq_lookup(input logic [1:0] idx);
    case (idx)
      2'h0: acq_lookup = `ACQ_CLKS_6;
      2'h1: acq_lookup = `ACQ_CLKS_10;
      2'h2: acq_lookup = `ACQ_CLKS_18;
      default: acq_lookup = `ACQ_CLKS_34;
    endcase
  endfunction : acq_lookup

  // edges come from the second and third stages, never from the first
  assign cs_low = !st.s2.cs_n;
  assign cs_fall = st.s3.cs_n && !st.s2.cs_n;
  assign cs_rise = !st.s3.cs_n && st.s2.cs_n;
  assign sclk_rise = !st.s3.sclk && st.s2.sclk;
  assign sclk_fall = st.s3.sclk && !st.s2.sclk;
  assign conversion_clock_rise = !st.s3.conversion_clock && st.s2.conversion_clock;
  assign converting = (st.seq == SEQ_ACQ) || (st.seq == SEQ_CONV);
  assign powered_now = !st.s2.pd && !st.sw_pd;
  assign acq_len = acq_lookup(st.acq_idx);
  assign cur_len = 5'(`WORD_BASE_LEN + (st.fmt.wide ? `WORD_WIDE_EXTRA : 5'h00)
                   + {4'h0, st.fmt.sign});

  // with select held low a frame is exactly one output word long
  assign last_bit = cs_low && sclk_rise && (5'(st.bit_cnt + 5'h01) == st.frame_len);
  assign frame_end = cs_rise || last_bit;
  assign instr_ok = last_bit || (st.bit_cnt >= `INSTR_BITS);
  // only a frame end after at least eight bits, with convert-select low and power pin low, decodes an instruction
  assign dec_cmd = (frame_end && instr_ok && !st.s2.conv_n && !st.s2.pd) ?
                   decode_instr(st.instr) : CMD_NONE;

  always_comb begin
    status_word = '0;
    status_word[`ST_PUP] = st.pup_busy;
    status_word[`ST_PDN] = st.pdn_busy;
    status_word[`ST_CAL] = (st.seq == SEQ_CAL);
    status_word[`ST_UNUSED] = 1'b0;
    status_word[`ST_FMT_NARROW] = !st.fmt.wide;
    status_word[`ST_FMT_WIDE] = st.fmt.wide;
    status_word[`ST_SIGN] = st.fmt.sign;
    status_word[`ST_MSB_FIRST] = !st.fmt.lsb_first;
    status_word[`ST_TEST] = st.test;
  end

  assign load_word = (st.kind == OUT_STATUS) ? {8'h00, status_word} :
                     (st.kind == OUT_RESULT) ? st.result : st.lfsr;

  adc_word_formatter u_formatter (
    .i_fmt(st.fmt),
    .i_sign(i_sar_sign),
    .i_mag(i_sar_mag),
    .o_word(fmt_word)
  );

  always_comb begin
    next_st = st;
    next_st.s1 = '{conversion_clock: i_conversion_clock, sclk: i_sclk, di: i_serial_instr_in,
                   cs_n: i_cs_n, conv_n: i_conv_n, pd: i_powerdown_pin};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lfsr = {st.lfsr[15:0], st.lfsr[16] ^ st.lfsr[13]};

    // serial side: sample on rises, shift on falls
    if (cs_low && sclk_rise) begin
      if (st.bit_cnt < `INSTR_BITS) begin
        next_st.instr[st.bit_cnt[2:0]] = st.s2.di;
      end
      if (st.bit_cnt != `BIT_CNT_MAX) begin
        next_st.bit_cnt = 5'(st.bit_cnt + 5'h01);
      end
    end
    if (cs_low && sclk_fall) begin
      if (st.reload) begin
        next_st.out_sr = load_word;
        next_st.reload = 1'b0;
      end else begin
        next_st.out_sr = {1'b0, st.out_sr[16:1]};
      end
    end
    if (last_bit) begin
      // the next word leaves on the following fall, no select edge to load it
      next_st.bit_cnt = 5'h00;
      next_st.reload = 1'b1;
    end
    if (cs_fall) begin
      next_st.bit_cnt = 5'h00;
      next_st.reload = 1'b0;
      next_st.out_sr = load_word;
      next_st.frame_len = cur_len;
    end

    // conversion and trim sequencer on conversion-clock rises
    if (conversion_clock_rise) begin
      case (st.seq)
        SEQ_ACQ: begin
          next_st.cnt = 16'(st.cnt + 16'h0001);
          if (16'(st.cnt + 16'h0001) >= {10'h000, acq_len}) begin
            next_st.seq = SEQ_CONV;
            next_st.cnt = 16'h0000;
          end
        end
        SEQ_CONV: begin
          next_st.cnt = 16'(st.cnt + 16'h0001);
          if (16'(st.cnt + 16'h0001) >= CONV_CLKS) begin
            next_st.seq = SEQ_IDLE;
            next_st.result = fmt_word;
            next_st.eoc = 1'b1;
          end
        end
        SEQ_CAL: begin
          next_st.cnt = 16'(st.cnt + 16'h0001);
          if (16'(st.cnt + 16'h0001) >= CAL_CLKS) begin
            next_st.seq = SEQ_IDLE;
          end
        end
        SEQ_ZERO: begin
          next_st.cnt = 16'(st.cnt + 16'h0001);
          if (16'(st.cnt + 16'h0001) >= ZERO_CLKS) begin
            next_st.seq = SEQ_IDLE;
          end
        end
        default: begin
          next_st.cnt = 16'h0000;
        end
      endcase
      if (st.pup_busy || st.pdn_busy) begin
        next_st.pwr_cnt = 16'(st.pwr_cnt + 16'h0001);
        if (st.pup_busy && 16'(st.pwr_cnt + 16'h0001) >= PUP_CLKS) begin
          next_st.pup_busy = 1'b0;
        end
        if (st.pdn_busy && 16'(st.pwr_cnt + 16'h0001) >= PDN_CLKS) begin
          next_st.pdn_busy = 1'b0;
        end
      end
    end

    // a new select strobe cuts a running conversion short
    if (cs_fall && converting) begin
      next_st.seq = SEQ_IDLE;
      next_st.eoc = 1'b1;
    end

    case (dec_cmd)
      CMD_CONV: begin
        next_st.fmt.lsb_first = st.instr[5];
        next_st.fmt.wide = st.instr[7];
        next_st.chan = '{single_ended: st.instr[0], polarity_odd: st.instr[1],
                         pair: st.instr[3:2]};
        next_st.kind = OUT_RESULT;
        if (powered_now && st.seq == SEQ_IDLE) begin
          next_st.seq = SEQ_ACQ;
          next_st.cnt = 16'h0000;
          next_st.eoc = 1'b0;
        end
      end
      CMD_CAL: begin
        next_st.seq = SEQ_CAL;
        next_st.cnt = 16'h0000;
        next_st.kind = OUT_GARBAGE;
      end
      CMD_ZERO: begin
        next_st.seq = SEQ_ZERO;
        next_st.cnt = 16'h0000;
      end
      CMD_PUP: next_st.sw_pd = 1'b0;
      CMD_PDN: next_st.sw_pd = 1'b1;
      CMD_STATUS: next_st.kind = OUT_STATUS;
      CMD_SIGN: next_st.fmt.sign = st.instr[0];
      CMD_ACQ: next_st.acq_idx = {st.instr[0], st.instr[1]};
      CMD_USER: next_st.test = 1'b0;
      CMD_TEST: next_st.test = 1'b1;
      default: begin
      end
    endcase

    // hardware power-down overrides everything; taking it high also undoes software power-down
    if (st.s2.pd) begin
      next_st.sw_pd = 1'b0;
    end
    if (!powered_now) begin
      if (converting) begin
        next_st.result = st.lfsr;
        next_st.eoc = 1'b1;
      end
      if (st.seq != SEQ_IDLE) begin
        next_st.seq = SEQ_IDLE;
      end
    end
    if (powered_now != st.powered) begin
      next_st.powered = powered_now;
      next_st.pup_busy = powered_now;
      next_st.pdn_busy = !powered_now;
      next_st.pwr_cnt = 16'h0000;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
      st.s1 <= '{conversion_clock: 1'b0, sclk: 1'b0, di: 1'b0, cs_n: 1'b1, conv_n: 1'b1, pd: 1'b0};
      st.s2 <= '{conversion_clock: 1'b0, sclk: 1'b0, di: 1'b0, cs_n: 1'b1, conv_n: 1'b1, pd: 1'b0};
      st.s3 <= '{conversion_clock: 1'b0, sclk: 1'b0, di: 1'b0, cs_n: 1'b1, conv_n: 1'b1, pd: 1'b0};
      st.seq <= SEQ_IDLE;
      st.powered <= 1'b1;
      st.fmt <= '{wide: `WIDE_RESET, lsb_first: `LSB_FIRST_RESET, sign: `SIGN_RESET};
      st.acq_idx <= `ACQ_IDX_RESET;
      st.test <= `TEST_RESET;
      st.frame_len <= `WORD_BASE_LEN + 5'h01;
      st.kind <= OUT_GARBAGE;
      st.lfsr <= `LFSR_RESET;
      st.eoc <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_data_out = st.out_sr[0];
  assign o_eoc = st.eoc;
  assign o_acquiring = (st.seq == SEQ_ACQ);
  assign o_powered = st.powered;
  assign o_analog_channels_oe = st.test;
  assign o_chan = st.chan;

  property p_eoc_low;
    @(posedge i_core_clk) disable iff (!i_nrst)
      converting |-> !o_eoc;
  endproperty
  a_eoc_low: assert property (p_eoc_low) else $error("eoc high during conversion");

  property p_conv_start;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (dec_cmd == CMD_CONV && powered_now && st.seq == SEQ_IDLE && !cs_fall)
      |=> (st.seq == SEQ_ACQ) && !o_eoc && (st.fmt.wide == $past(st.instr[7]));
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion not started");

  property p_cal_start;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (dec_cmd == CMD_CAL && powered_now) |=> status_word[`ST_CAL] && st.kind == OUT_GARBAGE;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("self-trim not flagged");

  property p_sign_set;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (dec_cmd == CMD_SIGN) |=> st.fmt.sign == $past(st.instr[0]) && st.seq == $past(st.seq);
  endproperty
  a_sign_set: assert property (p_sign_set) else $error("sign setting wrong");

  property p_acq_len;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (dec_cmd == CMD_ACQ && st.instr[1:0] == 2'h3) |=> acq_len == `ACQ_CLKS_34;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition length wrong");

  property p_test_mode;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (dec_cmd == CMD_TEST) |=> o_analog_channels_oe [*2];
  endproperty
  a_test_mode: assert property (p_test_mode) else $error("test mode not entered");

  property p_read_only;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (frame_end && st.s2.conv_n) |-> dec_cmd == CMD_NONE
        ##1 (st.fmt == $past(st.fmt) && st.kind == $past(st.kind)
        && st.test == $past(st.test) && st.acq_idx == $past(st.acq_idx));
  endproperty
  a_read_only: assert property (p_read_only) else $error("decode with convert-select high");

  property p_status_fmt;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (!status_word[`ST_UNUSED] && (status_word[`ST_FMT_NARROW] != status_word[`ST_FMT_WIDE]))
      and ((dec_cmd == CMD_CONV) |=> status_word[`ST_FMT_WIDE] == $past(st.instr[7])
        && status_word[`ST_MSB_FIRST] == !$past(st.instr[5]));
  endproperty
  a_status_fmt: assert property (p_status_fmt) else $error("status format bits wrong");

  property p_cs_abort;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (converting && cs_fall) |=> st.seq == SEQ_IDLE && o_eoc;
  endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("conversion not ended by select");

  property p_pd_abort;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (converting && st.s2.pd) |=> st.seq == SEQ_IDLE && st.result == $past(st.lfsr);
  endproperty
  a_pd_abort: assert property (p_pd_abort) else $error("power pin did not corrupt");

  property p_pup_flag;
    @(posedge i_core_clk) disable iff (!i_nrst)
      $rose(st.powered) |-> st.pup_busy && !st.pdn_busy;
  endproperty
  a_pup_flag: assert property (p_pup_flag) else $error("power-up flag missing");

endmodule : adc_serial_instruction_decoder

// File: host_serial_port.sv
// host serial port model: frames instructions and collects the returned word
module host_serial_port (
  input wire logic i_core_clk,
  input wire logic i_data_out,
  output logic o_sclk,
  output logic o_di,
  output logic o_cs_n,
  output logic o_conv_n,
  output logic [16:0] o_word,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_sclk = 1'b0;
    o_di = 1'b0;
    o_cs_n = 1'b1;
    o_conv_n = 1'b0;
    o_word = 17'h0;
    o_done = 1'b0;
  end

  // half of an 80 ns shift clock period
  task automatic half;
    repeat (4) @(posedge i_core_clk);
  endtask : half

  // one strobed exchange; the shift clock stands still outside the frame
  task automatic frame(input logic [7:0] instr, input int nbits, input logic rd);
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    o_conv_n <= rd;
    o_word <= 17'h0;
    half();
    for (int i = 0; i < nbits; i++) begin
      o_di <= (i < 8) ? instr[i] : i[0];
      half();
      o_sclk <= 1'b1;
      half();
      // sampled late in the high phase, well clear of the next shift
      o_word[i] <= i_data_out;
      o_sclk <= 1'b0;
    end
    half();
    o_cs_n <= 1'b1;
    o_di <= ~o_di;
    half();
    o_conv_n <= 1'b0;
    o_done <= 1'b1;
    @(posedge i_core_clk);
    o_done <= 1'b0;
    half();
  endtask : frame
endmodule : host_serial_port

// File: adc_serial_instruction_decoder_test.sv
// self-checking bench for the serial instruction decoder
module adc_serial_instruction_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_serial_instruction_decoder_pkg::*;

  localparam int LIMIT = 60000;
  localparam logic [15:0] CAL_N = 16'h0040;
  localparam logic [15:0] CONV_N = 16'h0010;

  typedef struct packed {
    logic [16:0] w;
    logic [16:0] m;
  } note_type;

  logic clk, nrst, conversion_clock, pd_pin, sar_sign, sclk, di, cs_n, conv_n, done;
  logic data_out, eoc, acquiring, powered, chan_oe;
  logic [11:0] sar_mag;
  logic [16:0] word;
  logic [1:0] cdiv;
  logic [3:0] ch, mode;
  chan_sel_type chan;
  fmt_type fmt;
  note_type nt;
  note_type notes[$];
  int errors, total_checks, cycles, seed, n;
  int acq_tab[4] = '{6, 10, 18, 34};
  logic [3:0] mode_tab[4] = '{4'h0, 4'h8, 4'h2, 4'hA};
  logic [7:0] cmd_tab[5] = '{8'hD0, 8'h50, 8'hF1, 8'hF0, 8'h90};
  logic [4:0] pw_tab = 5'b11110;
  logic [4:0] oe_tab = 5'b00100;

  adc_serial_instruction_decoder #(
    .CONV_CLKS(CONV_N), .CAL_CLKS(CAL_N), .ZERO_CLKS(16'h0004),
    .PUP_CLKS(16'h0004), .PDN_CLKS(16'h0004)
  ) i_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_sclk(sclk), .i_serial_instr_in(di),
    .i_cs_n(cs_n), .i_conv_n(conv_n), .i_powerdown_pin(pd_pin),
    .i_conversion_clock(conversion_clock), .i_sar_sign(sar_sign), .i_sar_mag(sar_mag),
    .o_data_out(data_out), .o_eoc(eoc), .o_acquiring(acquiring), .o_powered(powered),
    .o_analog_channels_oe(chan_oe), .o_chan(chan)
  );

  host_serial_port i_host (
    .i_core_clk(clk), .i_data_out(data_out), .o_sclk(sclk), .o_di(di),
    .o_cs_n(cs_n), .o_conv_n(conv_n), .o_word(word), .o_done(done)
  );

  always #5 clk = ~clk;

  // conversion clock of 80 ns, stepped off the core clock
  always @(posedge clk) begin
    cdiv <= cdiv + 2'h1;
    if (cdiv == 2'h3) conversion_clock <= ~conversion_clock;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      $display("[ERR] %0t run timed out", $time);
      wrap_up();
    end
  end

  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        errors++;
        $display("[ERR] %0t frame with no expectation", $time);
      end else begin
        nt = notes.pop_front();
        if (nt.m !== 17'h0) check_word(word & nt.m, nt.w & nt.m);
      end
    end
  end

  function automatic logic [16:0] exp_word(fmt_type f, logic sg, logic [11:0] m);
    logic [16:0] r;
    int k;
    r = 17'h0;
    k = f.wide ? 4 : 0;
    if (f.lsb_first) begin
      r[11:0] = m;
      r[12] = f.sign & sg;
    end else begin
      if (f.sign) r[k] = sg;
      k = k + (f.sign ? 1 : 0);
      for (int i = 0; i < 12; i++) r[k + i] = m[11 - i];
    end
    return r;
  endfunction : exp_word

  function automatic int len(fmt_type f);
    return 12 + (f.wide ? 4 : 0) + (f.sign ? 1 : 0);
  endfunction : len

  task automatic check_word(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t level got %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic xfer(input logic [7:0] instr, input int nb, input logic rd,
                      input logic [16:0] w, input logic [16:0] m);
    notes.push_back(note_type'{w, m});
    i_host.frame(instr, nb, rd);
  endtask : xfer

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    conversion_clock = 1'b0;
    cdiv = 2'h0;
    pd_pin = 1'b0;
    sar_sign = 1'b0;
    sar_mag = 12'h000;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    seed = 32'h3C259EEF;
    fmt = '{1'b0, 1'b0, 1'b1};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    check_bit(eoc, 1'b1);
    check_bit(powered, 1'b1);
    check_bit(chan_oe, 1'b0);
    check_bit(acquiring, 1'b0);
    $display("reset values done");
    // first status after trim is garbage, the second shows trim still busy
    xfer(8'h10, 8, 1'b0, 17'h0, 17'h0);
    xfer(8'h30, 8, 1'b0, 17'h0, 17'h0);
    xfer(8'h30, 9, 1'b0, 17'h0D4, 17'h1FE);
    repeat (int'(CAL_N) * 8) @(posedge clk);
    xfer(8'h30, 9, 1'b0, 17'h0D0, 17'h1FF);
    $display("trim and status done");
    for (int i = 0; i < 8; i++) begin
      if (i[1:0] == 2'h0) begin
        xfer({7'h58, i[2]}, 8, 1'b0, 17'h0, 17'h0);
        fmt.sign = i[2];
      end
      xfer({6'h1C, i[0], i[1]}, 8, 1'b0, 17'h0, 17'h0);
      mode = mode_tab[i % 4];
      ch = 4'($random(seed));
      sar_sign <= 1'($random(seed));
      sar_mag <= 12'($random(seed));
      fmt.wide = mode[3];
      fmt.lsb_first = mode[1];
      xfer({mode, ch}, 8, 1'b0, 17'h0, 17'h0);
      for (n = 0; n < 40 && acquiring !== 1'b1; n++) @(posedge clk);
      check_bit(eoc, 1'b0);
      check_word({13'h0, chan}, {13'h0, ch[0], ch[1], ch[3:2]});
      for (n = 0; n < 400 && acquiring === 1'b1; n++) @(posedge clk);
      check_bit(n >= acq_tab[i % 4] * 8 - 16 && n <= acq_tab[i % 4] * 8 + 8, 1'b1);
      for (n = 0; n < 2000 && eoc !== 1'b1; n++) @(posedge clk);
      check_bit(eoc, 1'b1);
      xfer(8'h00, len(fmt), 1'b1, exp_word(fmt, sar_sign, sar_mag), (17'h1 << len(fmt)) - 17'h1);
    end
    $display("formats and acquisition done");
    // select falling mid-conversion must end it at once
    xfer(8'h00, len(fmt), 1'b0, 17'h0, 17'h0);
    for (n = 0; n < 40 && acquiring !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 400 && acquiring === 1'b1; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    check_bit(eoc, 1'b0);
    fork
      xfer(8'h30, 8, 1'b0, 17'h0, 17'h0);
    join_none
    repeat (12) @(posedge clk);
    check_bit(eoc, 1'b1);
    repeat (120) @(posedge clk);
    $display("abort done");
    for (int k = 0; k < 5; k++) begin
      xfer(cmd_tab[k], 8, 1'b0, 17'h0, 17'h0);
      check_bit(powered, pw_tab[k]);
      check_bit(chan_oe, oe_tab[k]);
    end
    // power pin raised during acquisition must cut the conversion short
    xfer(8'h00, 8, 1'b0, 17'h0, 17'h0);
    check_bit(eoc, 1'b0);
    pd_pin <= 1'b1;
    repeat (8) @(posedge clk);
    check_bit(powered, 1'b0);
    check_bit(eoc, 1'b1);
    check_bit(acquiring, 1'b0);
    pd_pin <= 1'b0;
    repeat (8) @(posedge clk);
    check_bit(powered, 1'b1);
    $display("commands and power pin done");
    wrap_up();
  end
endmodule : adc_serial_instruction_decoder_test
